/* File: core/arpc_pkg.sv */
`default_nettype none
package arpc_pkg;
  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam logic [WB_AW-1:0] ADR_MODE = 8'h00;
  localparam logic [WB_AW-1:0] ADR_FILTER = 8'h04;
  localparam logic [WB_AW-1:0] ADR_CHANNEL = 8'h08;
  localparam logic [WB_AW-1:0] ADR_STATUS = 8'h0C;
  localparam logic [WB_AW-1:0] ADR_DATA = 8'h10;
  localparam logic [WB_AW-1:0] ADR_OFFSET = 8'h14;
  localparam logic [WB_AW-1:0] ADR_GAIN = 8'h18;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_KEEP_BIT = 3;
  localparam int MODE_CHOPDIS_BIT = 4;
  localparam int ST_READY_BIT = 0;
  localparam int ST_CAL_BIT = 1;
  localparam int ST_PD_BIT = 2;
  localparam int ST_LOAD_BIT = 3;
  localparam int CH_W = 4;
  localparam int RATE_W = 8;
  localparam int DATA_W = 24;
  localparam int COUNT_W = 16;

  // ----------------------------------------
  // Operating-mode encodings
  // ----------------------------------------
  localparam logic [2:0] OP_PWRDN = 3'h0;
  localparam logic [2:0] OP_IDLE = 3'h1;
  localparam logic [2:0] OP_SINGLE = 3'h2;
  localparam logic [2:0] OP_CONT = 3'h3;
  localparam logic [2:0] OP_INT_ZERO = 3'h4;
  localparam logic [2:0] OP_INT_FULL = 3'h5;
  localparam logic [2:0] OP_SYS_ZERO = 3'h6;
  localparam logic [2:0] OP_SYS_FULL = 3'h7;

  // ----------------------------------------
  // Modulator source select and defaults
  // ----------------------------------------
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_ZERO = 2'h1;
  localparam logic [1:0] SRC_FULL = 2'h2;
  localparam logic [RATE_W-1:0] RATE_SLOWEST = 8'hFF;
  localparam logic [RATE_W-1:0] RATE_RESET = 8'h45;
  localparam logic [DATA_W-1:0] FACTORY_GAIN = 24'h400000;
  localparam int GAIN_FRAC = 22;
  localparam int SAMPLES_PER_STEP = 4;

  typedef enum logic [1:0] {ARPC_IDLE, ARPC_RUN, ARPC_CORRECT, ARPC_STORE} arpc_state_t;
endpackage
`default_nettype wire

/* File: core/arpc_coef_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module arpc_coef_mem #(
  parameter int W = 24,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // Array write, no reset on the storage
  always_ff @(posedge clk_sys) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

/* File: core/arpc_corr.sv */
`timescale 1ns/1ns
`default_nettype none
module arpc_corr #(
  parameter int W = 24,
  parameter int FRAC = 22
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic [W-1:0] raw,
  input wire logic [W-1:0] off,
  input wire logic [W-1:0] gain,
  output logic [W-1:0] res,
  output logic valid
);
  typedef struct packed {
    logic valid;
    logic [W-1:0] res;
  } arpc_corr_s_t;

  arpc_corr_s_t r_q, r_d;
  logic signed [W:0] diff;
  logic signed [2*W+1:0] prod;
  logic signed [2*W+1:0] shifted;

  // Offset removed first, then gain scaling
  always_comb begin
    diff = signed'({1'b0, raw}) - signed'({1'b0, off});
    prod = diff * signed'({1'b0, gain});
    shifted = prod >>> FRAC;
    r_d = r_q;
    r_d.valid = start;
    if (start) begin
      r_d.res = shifted[W-1:0];
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign res = r_q.res;
  assign valid = r_q.valid;

  AST_CORR_ORDER: assert property (@(posedge clk_sys) disable iff (reset)
    start |=> valid && res == $past(shifted[W-1:0]))
    else $error("corrected word does not match offset-then-gain order");
endmodule
`default_nettype wire

/* File: core/arpc_top.sv */
// Notes on behaviour
// - Reset pin low clears logic and registers
// - Reset low: ready high, accesses ignored
// - Mode field zero enters power-down
// - Mode field resets to power-down
// - Power-down keeps registers unless written; entry clears ready
// - Bus usable in power-down; ready forced high
// - Four calibration encodings of mode field
// - Factory gains loaded at power-on automatically
// - Calibration overwrites that channel's coefficient
// - Zero to offset, full to gain
// - Internal calibration switches modulator source
// - Chop on: calibrate at slowest rate
// - Chop off: calibrate at programmed rate
// - Subtract offset, then multiply by gain
// - Calibration end shown by ready status
// - Keepalive bit keeps oscillator in power-down
`timescale 1ns/1ns
`default_nettype none
module arpc_top #(
  parameter int CHANNELS = 10,
  parameter int STEP = arpc_pkg::SAMPLES_PER_STEP
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic mod_clk,
  input wire logic mod_bit,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [arpc_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [arpc_pkg::WB_DW-1:0] wb_dat_i,
  output logic [arpc_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rdy_n,
  output logic [1:0] mod_src_sel,
  output logic osc_enable
);
  import arpc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_s3;
    logic mbit_s1;
    logic mbit_s2;
    logic hold;
    logic [2:0] op_sel;
    logic osc_keep;
    logic chop_dis;
    logic [RATE_W-1:0] rate;
    logic [CH_W-1:0] chan;
    logic ready;
    logic [DATA_W-1:0] data;
    arpc_state_t st;
    logic [2:0] run_op;
    logic [COUNT_W-1:0] cnt;
    logic [DATA_W-1:0] ones;
    logic [1:0] src;
    logic osc_en;
    logic rdy_n;
    logic load_busy;
    logic [CH_W-1:0] load_idx;
    logic ack;
    logic [WB_DW-1:0] dat;
  } arpc_s_t;

  arpc_s_t r_q, r_d;
  logic [RATE_W-1:0] rate_eff;
  logic [COUNT_W-1:0] conv_len;
  logic mclk_rise;
  logic req, wr;
  logic off_we, gain_we;
  logic [CH_W-1:0] off_wa, gain_wa;
  logic [DATA_W-1:0] off_wd, gain_wd, off_rd, gain_rd, corr_res;
  logic corr_start, corr_valid;

  // Byte-lane merge for partial writes
  function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old, input logic [WB_DW-1:0] nw,
                                             input logic [3:0] sel);
    logic [WB_DW-1:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------
  // Coefficient storage and correction
  // ----------------------------------------
  arpc_coef_mem #(.W(DATA_W), .DEPTH(CHANNELS), .AW(CH_W)) u_off (
    .clk_sys(clk_sys), .reset(reset), .we(off_we), .waddr(off_wa), .wdata(off_wd),
    .raddr(r_q.chan), .rdata(off_rd)
  );
  arpc_coef_mem #(.W(DATA_W), .DEPTH(CHANNELS), .AW(CH_W)) u_gain (
    .clk_sys(clk_sys), .reset(reset), .we(gain_we), .waddr(gain_wa), .wdata(gain_wd),
    .raddr(r_q.chan), .rdata(gain_rd)
  );
  arpc_corr #(.W(DATA_W), .FRAC(GAIN_FRAC)) u_corr (
    .clk_sys(clk_sys), .reset(reset), .start(corr_start), .raw(r_d.ones), .off(off_rd),
    .gain(gain_rd), .res(corr_res), .valid(corr_valid)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    off_we = 1'b0;
    gain_we = 1'b0;
    off_wa = r_q.chan;
    gain_wa = r_q.chan;
    off_wd = r_q.ones;
    gain_wd = r_q.ones;
    corr_start = 1'b0;
    // Two-stage synchronisers for pin inputs
    r_d.pin_s1 = reset_pin_n;
    r_d.pin_s2 = r_q.pin_s1;
    r_d.mclk_s1 = mod_clk;
    r_d.mclk_s2 = r_q.mclk_s1;
    r_d.mclk_s3 = r_q.mclk_s2;
    r_d.mbit_s1 = mod_bit;
    r_d.mbit_s2 = r_q.mbit_s1;
    r_d.hold = ~r_q.pin_s2;
    mclk_rise = r_q.mclk_s2 & ~r_q.mclk_s3;
    req = wb_cyc_i & wb_stb_i & ~r_q.ack;
    wr = req & wb_we_i & ~r_q.hold;
    // Slowest rate forced for chopped calibration
    if (r_q.run_op[2] && !r_q.chop_dis) begin
      rate_eff = RATE_SLOWEST;
    end else begin
      rate_eff = r_q.rate;
    end
    conv_len = COUNT_W'((32'(rate_eff) + 32'd1) * 32'(STEP));
    // Factory gain loader after power-on or pin reset
    if (r_q.load_busy) begin
      gain_we = 1'b1;
      gain_wa = r_q.load_idx;
      gain_wd = FACTORY_GAIN;
      off_we = 1'b1;
      off_wa = r_q.load_idx;
      off_wd = '0;
      r_d.load_idx = r_q.load_idx + 1'b1;
      if (int'(r_q.load_idx) == CHANNELS - 1) begin
        r_d.load_busy = 1'b0;
      end
    end
    // Conversion and calibration sequencer
    case (r_q.st)
      ARPC_IDLE: begin
        if (!r_q.load_busy && r_q.op_sel != OP_PWRDN && r_q.op_sel != OP_IDLE) begin
          r_d.st = ARPC_RUN;
          r_d.run_op = r_q.op_sel;
          r_d.cnt = '0;
          r_d.ones = '0;
          // Internal calibrations use on-chip zero or full source
          case (r_q.op_sel)
            OP_INT_ZERO: r_d.src = SRC_ZERO;
            OP_INT_FULL: r_d.src = SRC_FULL;
            default: r_d.src = SRC_EXT;
          endcase
        end
      end
      ARPC_RUN: begin
        if (mclk_rise) begin
          r_d.cnt = r_q.cnt + 1'b1;
          r_d.ones = r_q.ones + DATA_W'(r_q.mbit_s2);
          if (r_q.cnt + 1'b1 == conv_len) begin
            r_d.src = SRC_EXT;
            if (r_q.run_op[2]) begin
              r_d.st = ARPC_STORE;
            end else begin
              r_d.st = ARPC_CORRECT;
              corr_start = 1'b1;
            end
          end
        end
      end
      ARPC_CORRECT: begin
        if (corr_valid) begin
          r_d.data = corr_res;
          r_d.ready = 1'b1;
          if (r_q.run_op == OP_SINGLE) begin
            r_d.op_sel = OP_IDLE;
          end
          r_d.st = ARPC_IDLE;
        end
      end
      ARPC_STORE: begin
        // Zero-scale result to offset, full-scale to gain
        if (r_q.run_op[0]) begin
          gain_we = ~r_q.load_busy;
        end else begin
          off_we = 1'b1;
        end
        r_d.ready = 1'b1;
        r_d.op_sel = OP_IDLE;
        r_d.st = ARPC_IDLE;
      end
      default: r_d.st = ARPC_IDLE;
    endcase
    // Register bus, answered one cycle after the request
    r_d.ack = req;
    if (req) begin
      r_d.dat = '0;
      if (!r_q.hold) begin
        case (wb_adr_i)
          ADR_MODE: r_d.dat = WB_DW'({r_q.chop_dis, r_q.osc_keep, r_q.op_sel});
          ADR_FILTER: r_d.dat = WB_DW'(r_q.rate);
          ADR_CHANNEL: r_d.dat = WB_DW'(r_q.chan);
          ADR_STATUS: r_d.dat = WB_DW'({r_q.load_busy, r_q.op_sel == OP_PWRDN,
                                       r_q.st != ARPC_IDLE && r_q.run_op[2], r_q.ready});
          ADR_DATA: begin
            r_d.dat = WB_DW'(r_q.data);
            if (!wb_we_i) begin
              r_d.ready = (r_q.st == ARPC_CORRECT && corr_valid) || r_q.st == ARPC_STORE;
            end
          end
          ADR_OFFSET: r_d.dat = WB_DW'(off_rd);
          ADR_GAIN: r_d.dat = WB_DW'(gain_rd);
          default: r_d.dat = '0;
        endcase
      end
    end
    if (wr) begin
      case (wb_adr_i)
        ADR_MODE: begin
          r_d.op_sel = 3'(merge(WB_DW'({r_q.chop_dis, r_q.osc_keep, r_q.op_sel}), wb_dat_i, wb_sel_i));
          r_d.osc_keep = wb_sel_i[0] ? wb_dat_i[MODE_KEEP_BIT] : r_q.osc_keep;
          r_d.chop_dis = wb_sel_i[0] ? wb_dat_i[MODE_CHOPDIS_BIT] : r_q.chop_dis;
          r_d.st = ARPC_IDLE;
          r_d.src = SRC_EXT;
          if (r_d.op_sel == OP_PWRDN) begin
            r_d.ready = 1'b0;
          end
        end
        ADR_FILTER: r_d.rate = RATE_W'(merge(WB_DW'(r_q.rate), wb_dat_i, wb_sel_i));
        ADR_CHANNEL: r_d.chan = CH_W'(merge(WB_DW'(r_q.chan), wb_dat_i, wb_sel_i));
        ADR_OFFSET: begin
          off_we = 1'b1;
          off_wd = DATA_W'(merge(WB_DW'(off_rd), wb_dat_i, wb_sel_i));
        end
        ADR_GAIN: begin
          gain_we = 1'b1;
          gain_wd = DATA_W'(merge(WB_DW'(gain_rd), wb_dat_i, wb_sel_i));
        end
        default: ;
      endcase
    end
    // Oscillator runs unless powered down without keepalive
    r_d.osc_en = (r_d.op_sel != OP_PWRDN) | r_d.osc_keep;
    r_d.rdy_n = ~r_d.ready;
    // Held reset pin returns everything to defaults
    if (r_q.hold) begin
      r_d.op_sel = OP_PWRDN;
      r_d.osc_keep = 1'b0;
      r_d.chop_dis = 1'b0;
      r_d.rate = RATE_RESET;
      r_d.chan = '0;
      r_d.ready = 1'b0;
      r_d.data = '0;
      r_d.st = ARPC_IDLE;
      r_d.run_op = OP_PWRDN;
      r_d.cnt = '0;
      r_d.ones = '0;
      r_d.src = SRC_EXT;
      r_d.osc_en = 1'b0;
      r_d.rdy_n = 1'b1;
      r_d.dat = '0;
      r_d.load_busy = 1'b1;
      r_d.load_idx = '0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_q <= '0;
      r_q.hold <= 1'b1;
      r_q.rdy_n <= 1'b1;
      r_q.load_busy <= 1'b1;
      r_q.rate <= RATE_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = r_q.dat;
  assign wb_ack_o = r_q.ack;
  assign rdy_n = r_q.rdy_n;
  assign mod_src_sel = r_q.src;
  assign osc_enable = r_q.osc_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_HOLD_DEFAULTS: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.hold |=> r_q.op_sel == OP_PWRDN && r_q.st == ARPC_IDLE && r_q.data == '0)
    else $error("held reset pin did not restore defaults");
  AST_HOLD_RDY: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.hold |=> rdy_n && wb_dat_o == '0 [*1])
    else $error("ready low or data answered during reset pin");
  AST_HOLD_NOWRITE: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.hold && $past(r_q.hold) && wb_cyc_i && wb_stb_i && wb_we_i |=> r_q.rate == RATE_RESET)
    else $error("write accepted while reset pin held");
  AST_PD_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    wr && wb_adr_i == ADR_MODE && wb_sel_i[0] && wb_dat_i[2:0] == OP_PWRDN |=> r_q.op_sel == OP_PWRDN ##1 rdy_n)
    else $error("power-down write did not take effect or left ready low");
  AST_PD_KEEP: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.op_sel == OP_PWRDN && !r_q.hold && !wr |=> $stable(r_q.data) && $stable(r_q.rate) && $stable(r_q.chan))
    else $error("register changed in power-down");
  AST_CAL_RATE: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.st == ARPC_RUN && r_q.run_op[2] |-> rate_eff == (r_q.chop_dis ? r_q.rate : RATE_SLOWEST))
    else $error("calibration rate wrong for chop setting");
  AST_CAL_SRC: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.st == ARPC_RUN && r_q.run_op[2:1] == 2'b10 |-> mod_src_sel == (r_q.run_op[0] ? SRC_FULL : SRC_ZERO))
    else $error("internal calibration not on internal source");
  AST_CAL_STORE: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.st == ARPC_STORE && !r_q.hold |-> (r_q.run_op[0] ? gain_we && gain_wd == r_q.ones : off_we && off_wd == r_q.ones))
    else $error("calibration result not stored in its coefficient");
  AST_CAL_DONE: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.st == ARPC_STORE && !r_q.hold |=> r_q.op_sel == OP_IDLE && r_q.ready ##1 !rdy_n)
    else $error("calibration end not signalled");
  AST_FACTORY: assert property (@(posedge clk_sys) disable iff (reset)
    r_q.load_busy |-> gain_we && gain_wd == FACTORY_GAIN && gain_wa == r_q.load_idx)
    else $error("factory gain load missing");
  AST_OSC: assert property (@(posedge clk_sys) disable iff (reset)
    !r_q.hold && !wr && r_q.op_sel == OP_PWRDN |-> ##1 osc_enable == $past(r_q.osc_keep))
    else $error("oscillator enable ignores keepalive");
endmodule
`default_nettype wire

/* File: sim/arpc_mod_src.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Modulator front-end model
// ----------------------------------------
module arpc_mod_src (
  input wire logic osc_on,
  input wire logic [1:0] src,
  input wire logic ext_bit,
  output logic mod_clk,
  output logic mod_bit
);
  import arpc_pkg::*;
  // Sample clock stands still while the oscillator is off
  initial begin
    mod_clk = 1'b0;
    forever begin
      #63 mod_clk = osc_on;
      #62 mod_clk = 1'b0;
    end
  end
  // Internal sources override the input pins
  assign mod_bit = (src == SRC_ZERO) ? 1'b0 : (src == SRC_FULL) ? 1'b1 : ext_bit;
endmodule
`default_nettype wire

/* File: sim/arpc_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module arpc_top_bench;
  import arpc_pkg::*;
  localparam int CH = 10;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reset_pin_n = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic rdy_n;
  logic osc_enable;
  logic mod_clk;
  logic mod_bit;
  logic ext_bit = 1'b0;
  logic [1:0] src;
  logic [31:0] e_m;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int n_checks = 0;
  int seed = 32'h9b14;
  int c;
  int o;
  int k;

  // ----------------------------------------
  // Design and front-end model
  // ----------------------------------------
  arpc_top #(.CHANNELS(CH), .STEP(4)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n), .mod_clk(mod_clk),
    .mod_bit(mod_bit), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .rdy_n(rdy_n),
    .mod_src_sel(src), .osc_enable(osc_enable)
  );
  arpc_mod_src i_mod (.osc_on(osc_enable), .src(src), .ext_bit(ext_bit), .mod_clk(mod_clk), .mod_bit(mod_bit));

  // Clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic wait_rdy();
    k = 0;
    while (rdy_n !== 1'b0 && k < 40000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(rdy_n, 1'b0)
  endtask

  // One calibration: start, watch source, wait ready, check result
  task automatic cal(input logic [2:0] op, input logic x, input logic [1:0] s, input logic [31:0] hi,
                     input logic [7:0] a, input logic [31:0] e);
    ext_bit <= x;
    wb(1'b1, ADR_MODE, hi | op);
    repeat (3) @(posedge clk_sys);
    `CHK(src, s)
    wait_rdy();
    rd(ADR_STATUS, 32'h1);
    rd(ADR_MODE, hi | OP_IDLE);
    rd(a, e);
    rd(ADR_DATA, 32'h0);
  endtask

  // Read monitor: compare oldest note with each read answer
  always @(posedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e_m = exp_q.pop_front();
      `CHK(dat_r, e_m)
    end
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (CH + 6) @(posedge clk_sys);
    `CHK(rdy_n, 1'b1)
    `CHK(osc_enable, 1'b0)
    rd(ADR_MODE, 32'h0);
    rd(ADR_FILTER, 32'h45);
    rd(ADR_STATUS, 32'h4);
    rd(ADR_GAIN, {8'h00, FACTORY_GAIN});
    rd(8'h1C, 32'h0);
    wb(1'b1, ADR_MODE, 32'h8);
    repeat (2) @(posedge clk_sys);
    `CHK(osc_enable, 1'b1)
    // Calibrations at programmed rate with chop off
    wb(1'b1, ADR_FILTER, 32'h1);
    c = {$random(seed)} % CH;
    wb(1'b1, ADR_CHANNEL, c);
    cal(OP_INT_ZERO, 1'b0, SRC_ZERO, 32'h10, ADR_OFFSET, 32'h0);
    cal(OP_INT_FULL, 1'b1, SRC_FULL, 32'h10, ADR_GAIN, 32'h8);
    cal(OP_SYS_ZERO, 1'b1, SRC_EXT, 32'h10, ADR_OFFSET, 32'h8);
    cal(OP_SYS_FULL, 1'b0, SRC_EXT, 32'h10, ADR_GAIN, 32'h0);
    wb(1'b1, ADR_CHANNEL, (c + 1) % CH);
    rd(ADR_GAIN, {8'h00, FACTORY_GAIN});
    // Chop on forces the slowest rate
    cal(OP_INT_FULL, 1'b1, SRC_FULL, 32'h0, ADR_GAIN, 32'h400);
    // Offset first, then gain of 1.5
    o = 2 * ({$random(seed)} % 4);
    wb(1'b1, ADR_OFFSET, o);
    wb(1'b1, ADR_GAIN, 32'h600000);
    ext_bit <= 1'b1;
    wb(1'b1, ADR_MODE, OP_SINGLE);
    wait_rdy();
    rd(ADR_DATA, (8 - o) * 3 / 2);
    repeat (3) @(posedge clk_sys);
    `CHK(rdy_n, 1'b1)
    // Power-down with a result pending
    wb(1'b1, ADR_MODE, OP_SINGLE);
    wait_rdy();
    wb(1'b1, ADR_MODE, OP_PWRDN);
    repeat (3) @(posedge clk_sys);
    `CHK(rdy_n, 1'b1)
    `CHK(osc_enable, 1'b0)
    rd(ADR_DATA, (8 - o) * 3 / 2);
    rd(ADR_OFFSET, o);
    rd(ADR_STATUS, 32'h4);
    // Reset pin: ignored access, then defaults
    reset_pin_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK(rdy_n, 1'b1)
    wb(1'b1, ADR_FILTER, 32'h12);
    rd(ADR_FILTER, 32'h0);
    reset_pin_n <= 1'b1;
    repeat (CH + 6) @(posedge clk_sys);
    rd(ADR_FILTER, 32'h45);
    rd(ADR_CHANNEL, 32'h0);
    rd(ADR_GAIN, {8'h00, FACTORY_GAIN});
    wb(1'b1, ADR_FILTER, 32'h1);
    rd(ADR_FILTER, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
